// ==== shared/tone_program_regs.vh ====
/*
 constants for the tone programming port and automodem status word.
 assumes inclusion by bare name from the core files; holds definitions only.
*/
`ifndef TONE_PROGRAM_REGS_VH
`define TONE_PROGRAM_REGS_VH

// control bus addresses
`define ADDR_PROG_PORT 8'hE8
`define ADDR_AM_STATUS 8'hEB

// automodem status word fields
`define AM_MSG_HI 15
`define AM_MSG_LO 10
`define AM_QUAL_HI 6
`define AM_QUAL_LO 4
`define AM_MODE_HI 3
`define AM_MODE_LO 0
`define AM_UNUSED_BITS 3'h0

// header words and sequence lengths
`define HDR_TX 16'h8000
`define HDR_RX 16'h8001
`define TX_WORDS 5'h10
`define RX_WORDS 5'h1A

// parameter memory map
`define MEM_TX_BASE 7'h00
`define MEM_RX_BASE 7'h10
`define MEM_ACT_BASE 7'h40
`define MEM_FILL_LAST 7'h59
`define MEM_TD_F1 7'h0C
`define MEM_TD_L1 7'h0D
`define MEM_TD_F2 7'h0E
`define MEM_TD_L2 7'h0F

// positions inside a receive sequence
`define RX_B0_S1C1 5'h02
`define RX_B0_S2C1 5'h07
`define RX_NCYC_C1 5'h0A
`define RX_MIN_C1 5'h0B
`define RX_MAX_C1 5'h0C
`define RX_B0_S1C2 5'h0F
`define RX_B0_S2C2 5'h14
`define RX_NCYC_C2 5'h17
`define RX_MIN_C2 5'h18
`define RX_MAX_C2 5'h19

// reset values: pair d 2130 Hz + 2750 Hz at about 100 mV rms
`define RST_TD_F1 16'h1C68
`define RST_TD_F2 16'h24AD
`define RST_TD_LVL 16'h0B1A
// reset values: receive detector for 2130 Hz + 2750 Hz
`define RST_COEF_UNITY 16'h2000
`define RST_NCYC 16'h000A
`define RST_MIN_C1 16'h002C
`define RST_MAX_C1 16'h002E
`define RST_MIN_C2 16'h0022
`define RST_MAX_C2 16'h0024

// timing
`define CLK_HZ 20000000
`define PROG_MAX_US 150
`define PROG_MAX_CYC (`PROG_MAX_US * (`CLK_HZ / 1000000))
`define PROG_ABSORB_CYC 3'h4
`define TICK_HZ 9600
`define TICK_DIV_CYC (`CLK_HZ / `TICK_HZ)

// level detector hysteresis thresholds
`define LVL_ON_THR 16'h0100
`define LVL_OFF_THR 16'h00C0

`endif

// ==== core/param_ram.v ====
/*
 parameter memory for tone pair words, 128 x 16, one write port and one
 registered read port. assumes the owner initialises contents after reset.
*/
`default_nettype none

module param_ram (
	input wire i_clock,
	input wire i_we,
	input wire [6:0] i_waddr,
	input wire [15:0] i_wdata,
	input wire [6:0] i_raddr,
	output reg [15:0] o_rdata
);

	reg [15:0] mem [0:127];

	always @(posedge i_clock) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end

endmodule // param_ram

`default_nettype wire

// ==== core/tone_program_bank.v ====
/*
 tone pair programming port, parameter memory sequencer, receive frequency
 and level detection, and automodem status word.
 assumes synchronous bus strobes, status fields from the modem core, and
 per-cycle pulses and levels from the external filter datapath.
*/
// Contract
// - status bits 9..7 always read zero
// - bits 6..4 report link quality
// - low mode codes report idle states
// - message update or field change flags
// - write-only programming port at E8
// - powersave and reset clear tone memory
// - write clears ready, set after absorb
// - transmit sequence header plus sixteen words
// - four transmit pairs, zeros mean silence
// - reset: pairs a-c silent, d dual
// - unprogrammed pairs keep previous values
// - receive sequence header plus twenty-six words
// - coefficients 15-bit signed, unity 8192
// - tick count within min/max accepts
// - two channels filter, measure, level detect (filtering is external; the bank only measures and level detects)
// - receive changes apply at next entry
// - reset receive defaults detect 2130+2750
// - read-only status word at EB
`default_nettype none
`include "tone_program_regs.vh"

module tone_program_bank (
	input wire i_clock,
	input wire i_sys_rst,
	input wire i_bus_wr,
	input wire i_bus_rd,
	input wire [7:0] i_bus_addr,
	input wire [15:0] i_bus_wdata,
	input wire i_powersave,
	input wire i_tone_detect_mode,
	input wire i_msg_update,
	input wire [5:0] i_msg_code,
	input wire [2:0] i_link_quality_field,
	input wire [3:0] i_rate_mode,
	input wire [6:0] i_param_addr,
	input wire [1:0] i_rx_cycle,
	input wire [31:0] i_rx_level,
	output reg [15:0] o_rdata,
	output reg o_rdata_valid,
	output reg o_prog_ready,
	output reg o_status_change,
	output wire [15:0] o_param_data,
	output reg [1:0] o_tone_detect
);

	localparam ST_INIT = 4'h1;
	localparam ST_IDLE = 4'h2;
	localparam ST_BUSY = 4'h4;
	localparam ST_COPY = 4'h8;
	localparam integer TICK_RELOAD = `TICK_DIV_CYC - 1;

	reg [3:0] state_r;
	reg [3:0] state_nxt;
	reg [6:0] fill_r;
	reg [2:0] busy_r;
	reg [4:0] cp_idx_r;
	reg cp_wr_r;
	reg [4:0] cp_pos_r;
	reg seq_act_r;
	reg seq_rx_r;
	reg [4:0] pos_r;
	reg copy_pend_r;
	reg ps_d_r;
	reg det_d_r;
	reg [15:0] status_r;
	reg [11:0] tick_r;
	reg tick_en_r;
	reg mem_we;
	reg [6:0] mem_waddr;
	reg [15:0] mem_wdata;
	reg [6:0] mem_raddr;
	wire [15:0] mem_rdata;
	wire prog_wr;
	wire ps_rise;
	wire det_rise;
	wire word_store;

	// reset contents of one memory word
	function [15:0] default_word;
		input [6:0] a;
		reg [4:0] k;
		begin
			k = (a >= `MEM_ACT_BASE) ? a[4:0] : (a[4:0] ^ 5'h10);
			default_word = 16'h0000;
			if (a == `MEM_TD_F1) begin
				default_word = `RST_TD_F1;
			end else if (a == `MEM_TD_F2) begin
				default_word = `RST_TD_F2;
			end else if (a == `MEM_TD_L1 || a == `MEM_TD_L2) begin
				default_word = `RST_TD_LVL;
			end else if ((a >= `MEM_RX_BASE && a < 7'h2A) || a >= `MEM_ACT_BASE) begin
				case (k)
					`RX_B0_S1C1, `RX_B0_S2C1, `RX_B0_S1C2, `RX_B0_S2C2: begin
						default_word = `RST_COEF_UNITY;
					end
					`RX_NCYC_C1, `RX_NCYC_C2: begin
						default_word = `RST_NCYC;
					end
					`RX_MIN_C1: default_word = `RST_MIN_C1;
					`RX_MAX_C1: default_word = `RST_MAX_C1;
					`RX_MIN_C2: default_word = `RST_MIN_C2;
					`RX_MAX_C2: default_word = `RST_MAX_C2;
					default: default_word = 16'h0000;
				endcase
			end
		end
	endfunction

	assign prog_wr = i_bus_wr && (i_bus_addr == `ADDR_PROG_PORT) && (state_r == ST_IDLE);
	assign ps_rise = i_powersave && !ps_d_r;
	assign det_rise = i_tone_detect_mode && !det_d_r;
	assign word_store = prog_wr && seq_act_r && (i_bus_wdata != `HDR_TX)
		&& (i_bus_wdata != `HDR_RX);

	param_ram u_ram (
		.i_clock(i_clock),
		.i_we(mem_we),
		.i_waddr(mem_waddr),
		.i_wdata(mem_wdata),
		.i_raddr(mem_raddr),
		.o_rdata(mem_rdata)
	);
	assign o_param_data = mem_rdata;

	// memory port steering
	always @* begin
		mem_we = 1'b0;
		mem_waddr = 7'h00;
		mem_wdata = 16'h0000;
		mem_raddr = i_param_addr;
		if (state_r == ST_INIT) begin
			mem_we = 1'b1;
			mem_waddr = fill_r;
			mem_wdata = default_word(fill_r);
		end else if (state_r == ST_COPY) begin
			mem_we = cp_wr_r;
			mem_waddr = `MEM_ACT_BASE + {2'b00, cp_pos_r};
			mem_wdata = mem_rdata;
			mem_raddr = `MEM_RX_BASE + {2'b00, cp_idx_r};
		end else if (word_store) begin
			mem_we = 1'b1;
			mem_waddr = (seq_rx_r ? `MEM_RX_BASE : `MEM_TX_BASE) + {2'b00, pos_r};
			mem_wdata = i_bus_wdata;
		end
	end

	// sequencer next state
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_INIT: begin
				if (fill_r == `MEM_FILL_LAST) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (prog_wr) begin
					state_nxt = ST_BUSY;
				end else if (det_rise || copy_pend_r) begin
					state_nxt = ST_COPY;
				end
			end
			ST_BUSY: begin
				if (busy_r == 3'h1) begin
					state_nxt = copy_pend_r ? ST_COPY : ST_IDLE;
				end
			end
			ST_COPY: begin
				if (cp_wr_r && cp_pos_r == `RX_WORDS - 5'h01) begin
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_INIT;
		endcase
		if (ps_rise) begin
			state_nxt = ST_INIT;
		end
	end

	always @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_r <= ST_INIT;
			fill_r <= 7'h00;
			busy_r <= 3'h0;
			cp_idx_r <= 5'h00;
			cp_wr_r <= 1'b0;
			cp_pos_r <= 5'h00;
			seq_act_r <= 1'b0;
			seq_rx_r <= 1'b0;
			pos_r <= 5'h00;
			copy_pend_r <= 1'b0;
			ps_d_r <= 1'b0;
			det_d_r <= 1'b0;
			o_prog_ready <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ps_d_r <= i_powersave;
			det_d_r <= i_tone_detect_mode;
			o_prog_ready <= (state_nxt == ST_IDLE);
			fill_r <= (state_nxt == ST_INIT && state_r == ST_INIT) ? fill_r + 7'h01 : 7'h00;
			busy_r <= (state_r == ST_BUSY) ? busy_r - 3'h1 : `PROG_ABSORB_CYC;
			if (state_r == ST_COPY) begin
				cp_idx_r <= cp_idx_r + 5'h01;
				cp_wr_r <= 1'b1;
				cp_pos_r <= cp_idx_r;
			end else begin
				cp_idx_r <= 5'h00;
				cp_wr_r <= 1'b0;
				cp_pos_r <= 5'h00;
			end
			// a fresh entry during busy or copy wins over the clear
			if (det_rise && state_r != ST_IDLE) begin
				copy_pend_r <= 1'b1;
			end else if (state_nxt == ST_COPY) begin
				copy_pend_r <= 1'b0;
			end else if (det_rise) begin
				copy_pend_r <= 1'b1;
			end
			if (state_r == ST_INIT) begin
				seq_act_r <= 1'b0;
				copy_pend_r <= 1'b0;
			end else if (prog_wr) begin
				if (i_bus_wdata == `HDR_TX || i_bus_wdata == `HDR_RX) begin
					seq_act_r <= 1'b1;
					seq_rx_r <= (i_bus_wdata == `HDR_RX);
					pos_r <= 5'h00;
				end else if (word_store) begin
					pos_r <= pos_r + 5'h01;
					if (pos_r == (seq_rx_r ? `RX_WORDS : `TX_WORDS) - 5'h01) begin
						seq_act_r <= 1'b0;
					end
				end
			end
		end
	end

	// status word and read port
	always @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			status_r <= 16'h0000;
			o_status_change <= 1'b0;
			o_rdata <= 16'h0000;
			o_rdata_valid <= 1'b0;
		end else begin
			status_r <= {(i_msg_update ? i_msg_code : status_r[`AM_MSG_HI:`AM_MSG_LO]),
				`AM_UNUSED_BITS, i_link_quality_field, i_rate_mode};
			o_status_change <= i_msg_update
				|| (i_link_quality_field != status_r[`AM_QUAL_HI:`AM_QUAL_LO])
				|| (i_rate_mode != status_r[`AM_MODE_HI:`AM_MODE_LO]);
			o_rdata_valid <= i_bus_rd;
			o_rdata <= (i_bus_rd && i_bus_addr == `ADDR_AM_STATUS) ? status_r : 16'h0000;
		end
	end

	// 9.6 kHz timer enable
	always @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			tick_r <= 12'h000;
			tick_en_r <= 1'b0;
		end else begin
			tick_en_r <= (tick_r == 12'h001);
			tick_r <= (tick_r == 12'h000) ? TICK_RELOAD[11:0] : tick_r - 12'h001;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
			reg [15:0] ncyc_r;
			reg [15:0] tmin_r;
			reg [15:0] tmax_r;
			reg [15:0] cyc_r;
			reg [15:0] ticks_r;
			reg freq_ok_r;
			reg lvl_on_r;
			wire [15:0] lvl;
			wire [4:0] p_ncyc;
			assign lvl = i_rx_level[ch * 16 +: 16];
			assign p_ncyc = (ch == 0) ? `RX_NCYC_C1 : `RX_NCYC_C2;
			always @(posedge i_clock or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					ncyc_r <= `RST_NCYC;
					tmin_r <= (ch == 0) ? `RST_MIN_C1 : `RST_MIN_C2;
					tmax_r <= (ch == 0) ? `RST_MAX_C1 : `RST_MAX_C2;
					cyc_r <= 16'h0000;
					ticks_r <= 16'h0000;
					freq_ok_r <= 1'b0;
					lvl_on_r <= 1'b0;
				end else begin
					if (state_r == ST_INIT) begin
						ncyc_r <= `RST_NCYC;
						tmin_r <= (ch == 0) ? `RST_MIN_C1 : `RST_MIN_C2;
						tmax_r <= (ch == 0) ? `RST_MAX_C1 : `RST_MAX_C2;
					end else if (state_r == ST_COPY && cp_wr_r) begin
						if (cp_pos_r == p_ncyc) ncyc_r <= mem_rdata;
						if (cp_pos_r == p_ncyc + 5'h01) tmin_r <= mem_rdata;
						if (cp_pos_r == p_ncyc + 5'h02) tmax_r <= mem_rdata;
					end
					if (tick_en_r && ticks_r != 16'hFFFF) begin
						ticks_r <= ticks_r + 16'h0001;
					end
					if (!i_tone_detect_mode) begin
						cyc_r <= 16'h0000;
						ticks_r <= 16'h0000;
						freq_ok_r <= 1'b0;
					end else if (i_rx_cycle[ch]) begin
						if (cyc_r + 16'h0001 >= ncyc_r) begin
							freq_ok_r <= (ticks_r >= tmin_r) && (ticks_r <= tmax_r);
							cyc_r <= 16'h0000;
							ticks_r <= 16'h0000;
						end else begin
							cyc_r <= cyc_r + 16'h0001;
						end
					end
					// hysteresis level detector
					if (lvl >= `LVL_ON_THR) begin
						lvl_on_r <= 1'b1;
					end else if (lvl < `LVL_OFF_THR) begin
						lvl_on_r <= 1'b0;
					end
				end
			end
		end
	endgenerate

	always @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_tone_detect <= 2'h0;
		end else begin
			o_tone_detect[0] <= g_chan[0].freq_ok_r && g_chan[0].lvl_on_r;
			o_tone_detect[1] <= g_chan[1].freq_ok_r && g_chan[1].lvl_on_r;
		end
	end

endmodule // tone_program_bank

`default_nettype wire

// ==== dv/tone_program_bank_assertions.sv ====
/*
 port checker for the tone programming bank.
 assumes one clock domain and a bind to every bank instance.
*/
`default_nettype none
module tone_program_bank_assertions (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_bus_wr,
	input wire logic i_bus_rd,
	input wire logic [7:0] i_bus_addr,
	input wire logic i_powersave,
	input wire logic i_msg_update,
	input wire logic [2:0] i_link_quality_field,
	input wire logic [3:0] i_rate_mode,
	input wire logic [15:0] o_rdata,
	input wire logic o_rdata_valid,
	input wire logic o_prog_ready,
	input wire logic o_status_change
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int ABSORB_MAX = 1000;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	sequence prog_taken;
		i_bus_wr && i_bus_addr == 8'hE8 && o_prog_ready;
	endsequence
	sequence status_rd;
		i_bus_rd && i_bus_addr == 8'hEB && !$past(i_sys_rst);
	endsequence
	unused_zero_a: assert property (o_rdata_valid |-> o_rdata[9:7] == 3'h0)
		else $error("status bits 9..7 not zero");
	quality_read_a: assert property (status_rd ##0 $stable(i_link_quality_field)
		|=> o_rdata[6:4] == $past(i_link_quality_field)) else $error("quality field wrong");
	mode_read_a: assert property (status_rd ##0 $stable(i_rate_mode)
		|=> o_rdata[3:0] == $past(i_rate_mode)) else $error("mode field wrong");
	read_answer_a: assert property (i_bus_rd |=> o_rdata_valid)
		else $error("read not answered");
	port_wo_a: assert property (i_bus_rd && i_bus_addr != 8'hEB |=> o_rdata == 16'h0000)
		else $error("non status read not zero");
	change_flag_a: assert property (!$past(i_sys_rst) && (i_msg_update
		|| i_link_quality_field != $past(i_link_quality_field)
		|| i_rate_mode != $past(i_rate_mode)) |=> o_status_change) else $error("no change pulse");
	ready_drop_a: assert property (prog_taken |=> !o_prog_ready)
		else $error("ready not cleared by write");
	ready_back_a: assert property (prog_taken |-> ##[2:ABSORB_MAX] o_prog_ready)
		else $error("ready not restored");
	ps_clear_a: assert property ($rose(i_powersave) |-> ##[1:2] !o_prog_ready)
		else $error("powersave did not start clear");
endmodule // tone_program_bank_assertions

bind tone_program_bank tone_program_bank_assertions u_chk (
	.i_clock(i_clock),
	.i_sys_rst(i_sys_rst),
	.i_bus_wr(i_bus_wr),
	.i_bus_rd(i_bus_rd),
	.i_bus_addr(i_bus_addr),
	.i_powersave(i_powersave),
	.i_msg_update(i_msg_update),
	.i_link_quality_field(i_link_quality_field),
	.i_rate_mode(i_rate_mode),
	.o_rdata(o_rdata),
	.o_rdata_valid(o_rdata_valid),
	.o_prog_ready(o_prog_ready),
	.o_status_change(o_status_change)
);
`default_nettype wire

// ==== dv/host_model.sv ====
/*
 host controller model driving the control bus strobes.
 assumes registered answers one edge after each strobe.
*/
`default_nettype none
module host_model (
	input wire logic i_clock,
	input wire logic i_prog_ready,
	input wire logic [15:0] i_rdata,
	output logic o_bus_wr,
	output logic o_bus_rd,
	output logic [7:0] o_bus_addr,
	output logic [15:0] o_bus_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_bus_wr = 1'b0;
		o_bus_rd = 1'b0;
		o_bus_addr = 8'h00;
		o_bus_wdata = 16'h0000;
	end
	task automatic write_word(input logic [15:0] w, output bit ok);
		int n;
		ok = 1'b0;
		for (n = 0; n < 4000 && !ok; n++) begin
			@(negedge i_clock);
			ok = (i_prog_ready === 1'b1);
		end
		if (ok) begin
			@(posedge i_clock);
			o_bus_wr <= 1'b1;
			o_bus_addr <= 8'hE8;
			o_bus_wdata <= w;
			@(posedge i_clock);
			o_bus_wr <= 1'b0;
			o_bus_wdata <= ~w;
			@(posedge i_clock);
		end
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge i_clock);
		o_bus_rd <= 1'b1;
		o_bus_addr <= a;
		@(posedge i_clock);
		o_bus_rd <= 1'b0;
		@(negedge i_clock);
		d = i_rdata;
	endtask
endmodule // host_model
`default_nettype wire

// ==== dv/testbench.sv ====
/*
 self-checking bench for the tone programming bank.
 assumes the bank's reset fill and the host model's bus timing.
*/
`default_nettype none
`include "tone_program_regs.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clock = 1'b0;
	logic i_sys_rst = 1'b1;
	logic bus_wr, bus_rd, rdata_valid, prog_ready, status_change;
	logic powersave = 1'b0, detect_mode = 1'b0, msg_update = 1'b0;
	logic [7:0] bus_addr;
	logic [15:0] bus_wdata, rdata, param_data, d;
	logic [5:0] msg_code = 6'h00;
	logic [2:0] quality = 3'h0;
	logic [3:0] rate_mode = 4'h0;
	logic [6:0] param_addr = 7'h00;
	logic [1:0] tone_detect;
	logic [1:0] rx_cycle = 2'h0;
	logic [31:0] rx_level = 32'h00000000;
	logic lvl_on = 1'b0;
	logic [15:0] exp_mem [0:89];
	int err_count = 0;
	int comparisons = 0;
	integer seed = 32'hC271;
	bit ok;
	always #25 i_clock = ~i_clock;
	host_model host (.i_clock(i_clock), .i_prog_ready(prog_ready), .i_rdata(rdata),
		.o_bus_wr(bus_wr), .o_bus_rd(bus_rd), .o_bus_addr(bus_addr), .o_bus_wdata(bus_wdata));
	tone_program_bank DUT (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_bus_wr(bus_wr),
		.i_bus_rd(bus_rd), .i_bus_addr(bus_addr), .i_bus_wdata(bus_wdata),
		.i_powersave(powersave), .i_tone_detect_mode(detect_mode), .i_msg_update(msg_update),
		.i_msg_code(msg_code), .i_link_quality_field(quality), .i_rate_mode(rate_mode),
		.i_param_addr(param_addr), .i_rx_cycle(rx_cycle), .i_rx_level(rx_level),
		.o_rdata(rdata), .o_rdata_valid(rdata_valid), .o_prog_ready(prog_ready),
		.o_status_change(status_change), .o_param_data(param_data), .o_tone_detect(tone_detect));
	function automatic logic [15:0] dflt(input int a);
		case (a)
			12: dflt = `RST_TD_F1;
			13, 15: dflt = `RST_TD_LVL;
			14: dflt = `RST_TD_F2;
			18, 23, 31, 36: dflt = `RST_COEF_UNITY;
			26, 39: dflt = `RST_NCYC;
			27: dflt = `RST_MIN_C1;
			28: dflt = `RST_MAX_C1;
			40: dflt = `RST_MIN_C2;
			41: dflt = `RST_MAX_C2;
			default: dflt = 16'h0000;
		endcase
	endfunction
	function automatic logic [15:0] det_word(input int p);
		case (p)
			10, 12, 23: det_word = 16'h0001;
			11: det_word = 16'h0000;
			24: det_word = 16'h0002;
			25: det_word = 16'h0003;
			default: det_word = `RST_COEF_UNITY;
		endcase
	endfunction
	function automatic logic in_win(input int period, input int ch);
		int t;
		t = period / `TICK_DIV_CYC;
		in_win = (t >= det_word(11 + 13 * ch)) && (t + 1 <= det_word(12 + 13 * ch));
	endfunction
	task automatic report_and_stop();
		if (err_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] w);
		host.write_word(w, ok);
		if (!ok) begin
			err_count++;
			report_and_stop();
		end
	endtask
	task automatic cmp_mem(input int lo, input int hi);
		int a;
		for (a = lo; a <= hi; a++) begin
			@(posedge i_clock);
			param_addr <= a[6:0];
			@(posedge i_clock);
			@(negedge i_clock);
			cmp16(param_data, exp_mem[a]);
		end
	endtask
	task automatic prog(input logic [15:0] hdr, input int n, input int base);
		int i;
		logic [15:0] w;
		wr(hdr);
		for (i = 0; i < n; i++) begin
			w = 16'($random(seed)) & (hdr[0] ? 16'h7FFF : 16'h3FFF);
			wr(w);
			exp_mem[base + i] = w;
		end
	endtask
	task automatic enter_detect();
		int i;
		@(posedge i_clock);
		detect_mode <= 1'b1;
		for (i = 0; i < 26; i++)
			exp_mem[64 + i] = exp_mem[16 + i];
		repeat (60) @(posedge i_clock);
	endtask
	task automatic tone_check(input int period, input logic [15:0] lvl);
		int n;
		@(posedge i_clock);
		rx_level <= {lvl, lvl};
		lvl_on = (lvl >= `LVL_ON_THR) ? 1'b1 : ((lvl < `LVL_OFF_THR) ? 1'b0 : lvl_on);
		for (n = 0; n < 3; n++) begin
			repeat (period - 1) @(posedge i_clock);
			rx_cycle <= 2'h3;
			@(posedge i_clock);
			rx_cycle <= 2'h0;
		end
		@(posedge i_clock);
		@(negedge i_clock);
		cmp16({14'h0000, tone_detect}, {14'h0000, in_win(period, 1) & lvl_on,
			in_win(period, 0) & lvl_on});
	endtask
	initial begin
		int i;
		for (i = 0; i < 90; i++)
			exp_mem[i] = dflt(i < 64 ? i : i - 48);
		repeat (16) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		wr(16'h2AAA);
		cmp_mem(0, 41);
		wr(`HDR_TX);
		wr(16'h0D56);
		wr(16'h3781);
		wr(16'h0000);
		wr(16'h0000);
		exp_mem[0] = 16'h0D56;
		exp_mem[1] = 16'h3781;
		exp_mem[2] = 16'h0000;
		exp_mem[3] = 16'h0000;
		cmp_mem(0, 15);
		prog(`HDR_TX, 16, 0);
		wr(16'h1555);
		wr(16'h0AAA);
		cmp_mem(0, 41);
		prog(`HDR_RX, 26, 16);
		cmp_mem(16, 41);
		enter_detect();
		prog(`HDR_RX, 26, 16);
		cmp_mem(64, 89);
		@(posedge i_clock);
		detect_mode <= 1'b0;
		enter_detect();
		cmp_mem(64, 89);
		@(posedge i_clock);
		powersave <= 1'b1;
		for (i = 0; i < 42; i++)
			exp_mem[i] = dflt(i);
		repeat (4) @(posedge i_clock);
		wr(`HDR_TX);
		cmp_mem(0, 41);
		@(posedge i_clock);
		powersave <= 1'b0;
		@(posedge i_clock);
		msg_code <= 6'($random(seed));
		msg_update <= 1'b1;
		@(posedge i_clock);
		msg_update <= 1'b0;
		for (i = 0; i < 16; i++) begin
			@(posedge i_clock);
			quality <= i[2:0] ^ (3'($random(seed)) & ((i < 8) ? 3'h0 : 3'h7));
			rate_mode <= i[3:0];
			repeat (3) @(posedge i_clock);
			host.read_reg(8'hEB, d);
			cmp16(d, {msg_code, 3'h0, quality, rate_mode});
		end
		host.read_reg(8'hE8, d);
		cmp16(d, 16'h0000);
		@(posedge i_clock);
		detect_mode <= 1'b0;
		wr(`HDR_RX);
		for (i = 0; i < 26; i++) begin
			wr(det_word(i));
			exp_mem[16 + i] = det_word(i);
		end
		enter_detect();
		cmp_mem(64, 89);
		tone_check(1000, 16'h0100);
		tone_check(4500, 16'h00C0);
		tone_check(1000, 16'h00BF);
		for (i = 0; i < 2; i++) begin
			d = 16'($random(seed)) & 16'h01FF;
			tone_check((($random(seed) & 1) != 0) ? 4500 : 1000, d);
		end
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
